// ===== verilog/pmap_pkg.sv
// Shared constants and types for the master PCM audio port
// Operation
// - Port is timing master only; bit clock and frame sync are always outputs.
// - Frame sync repeats at 8 kHz, one frame every 125 us; with the default 6 ns link clock a 256-bit frame takes 122.88 us.
// - In short-sync framing, sync is high one bit period, then low.
// - Bit clock period 488 ns, symmetric, 244 ns high and 244 ns low; with the default 6 ns link clock the divider gives 480 ns, 240 ns each half.
// - Linear samples, 16-bit words, with 8-bit words selectable.
// - Each outgoing data bit is launched on a bit clock rising edge.
// - Data output goes high impedance after a falling edge past the last bit.
// - Port also supports I2S framing and TDM multi-slot framing.
package pmap_pkg;

  // Nominal link timing
  localparam int unsigned FRAME_RATE_HZ = 8000;
  localparam int unsigned FRAME_PERIOD_US = 125;
  localparam int unsigned BCLK_PERIOD_NS = 488;
  localparam int unsigned BCLK_HIGH_NS = 244;
  localparam int unsigned SYNC_HIGH_NS = 488;
  localparam int unsigned LINK_CLK_PS_DEF = 6000;
  localparam int unsigned PS_PER_NS = 1000;

  // Frame layout, counted in bit periods
  localparam int unsigned FRAME_BITS = 256;
  localparam logic [7:0] BIT_RESET = 8'hff;
  localparam logic [7:0] BIT_SYNC = 8'h00;
  localparam logic [7:0] BIT_FIRST = 8'h01;
  localparam logic [7:0] BIT_I2S_RIGHT = 8'h81;
  localparam int unsigned TDM_SLOTS = 4;
  localparam logic [4:0] TDM_SLOTS_W = 5'h04;

  // Word layout
  localparam int unsigned WORD_BITS = 16;
  localparam logic [3:0] WORD8_LAST = 4'h7;
  localparam logic [3:0] WORD16_LAST = 4'hf;
  localparam int unsigned FIFO_DEPTH = 16;

  // Framing modes
  typedef enum logic [1:0] {
    PMAP_MODE_PCM = 2'b00,
    PMAP_MODE_I2S = 2'b01,
    PMAP_MODE_TDM = 2'b10
  } pmap_mode_t;

  // Configuration carried as one group
  typedef struct packed {
    pmap_mode_t mode;
    logic word16;
  } pmap_cfg_t;

  // Mailbox handshake states on the system side
  typedef enum logic {
    PMAP_MB_IDLE = 1'b0,
    PMAP_MB_WAIT = 1'b1
  } pmap_mb_state_t;

endpackage

// ===== verilog/pmap_port.sv
// Master PCM/I2S/TDM audio port with transmit FIFO and clock crossing
`timescale 1ns/1ps

module pmap_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_EMPTY = '0;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == PTR_LAST) ? '0 : AW'(p + 1'b1);
  endfunction

  // Handshakes on both sides
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  // Occupancy next value
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW + 1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW + 1)'(cnt_q - 1'b1);
    end
  end

  // Storage, written only while not full
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= ptr_next(wr_q);
      end
      if (pop) begin
        rd_q <= ptr_next(rd_q);
      end
      cnt_q <= cnt_d;
    end
  end

  // Flags registered so the ready reaching the source is a flop
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      in_ready_o <= (cnt_d != CNT_FULL);
      out_valid_o <= (cnt_d != CNT_EMPTY);
    end
  end
endmodule

module pmap_port import pmap_pkg::*; #(
  parameter int unsigned LINK_CLK_PS = LINK_CLK_PS_DEF
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire pmap_cfg_t cfg_i,
  input wire logic tx_valid_i,
  input wire logic [WORD_BITS-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [WORD_BITS-1:0] rx_data_o,
  output logic pcm_clk_o,
  output logic pcm_sync_o,
  output logic pcm_dout_o,
  output logic pcm_dout_oe_o,
  input wire logic pcm_din_i
);
  // Link clock cycles per bit clock half period, rounded down
  localparam int unsigned HALF_RAW = (BCLK_HIGH_NS * PS_PER_NS) / LINK_CLK_PS;
  localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : int'(HALF_RAW);
  localparam int BIT_CYC = 2 * HALF_CYC;
  localparam int FRAME_CYC = int'(FRAME_BITS) * BIT_CYC;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  function automatic logic [3:0] word_last(input logic word16);
    word_last = word16 ? WORD16_LAST : WORD8_LAST;
  endfunction

  // Slot start positions for each framing
  function automatic logic slot_start(input pmap_cfg_t c, input logic [7:0] b);
    logic [7:0] offs;
    offs = 8'(b - BIT_FIRST);
    case (c.mode)
      PMAP_MODE_I2S: slot_start = (b == BIT_FIRST) || (b == BIT_I2S_RIGHT);
      PMAP_MODE_TDM: begin
        if (c.word16) begin
          slot_start = (b != BIT_SYNC) && (offs[3:0] == 4'h0) && ({1'b0, offs[7:4]} < TDM_SLOTS_W);
        end else begin
          slot_start = (b != BIT_SYNC) && (offs[2:0] == 3'h0) && (offs[7:3] < TDM_SLOTS_W);
        end
      end
      default: slot_start = (b == BIT_FIRST);
    endcase
  endfunction

  // ---------------- System clock side ----------------
  logic fifo_valid;
  logic [WORD_BITS-1:0] fifo_data;
  logic fifo_ready;
  pmap_mb_state_t mb_state_q;
  logic [WORD_BITS-1:0] mbox_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic rxt_s1_q;
  logic rxt_s2_q;
  logic rxt_s3_q;
  // Link-side flops; ack_q and rx_tgl_q are read here through synchronisers, rx_word_q directly once its toggle arrives
  logic ack_q;
  logic [WORD_BITS-1:0] rx_word_q;
  logic rx_tgl_q;

  // Transmit words wait here; back-pressure reaches tx_ready_o
  pmap_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_ready)
  );

  // One word in flight across the crossing at a time
  assign fifo_ready = (mb_state_q == PMAP_MB_IDLE);

  // Acknowledge toggle from the link side, two flops
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Mailbox: word held stable until the link side acknowledges
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mb_state_q <= PMAP_MB_IDLE;
      mbox_q <= '0;
      req_q <= 1'b0;
    end else begin
      case (mb_state_q)
        PMAP_MB_IDLE: begin
          if (fifo_valid) begin
            mbox_q <= fifo_data;
            req_q <= ~req_q;
            mb_state_q <= PMAP_MB_WAIT;
          end
        end
        PMAP_MB_WAIT: begin
          if (ack_s2_q == req_q) begin
            mb_state_q <= PMAP_MB_IDLE;
          end
        end
        default: mb_state_q <= PMAP_MB_IDLE;
      endcase
    end
  end

  // Received words: toggle synchronised, word stable long before it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rxt_s1_q <= 1'b0;
      rxt_s2_q <= 1'b0;
      rxt_s3_q <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end else begin
      rxt_s1_q <= rx_tgl_q;
      rxt_s2_q <= rxt_s1_q;
      rxt_s3_q <= rxt_s2_q;
      rx_valid_o <= (rxt_s2_q != rxt_s3_q);
      if (rxt_s2_q != rxt_s3_q) begin
        rx_data_o <= rx_word_q;
      end
    end
  end

  // ---------------- Link clock side ----------------
  logic lrst_s1_q;
  logic link_rst;
  logic [2:0] cfg_s1_q;
  pmap_cfg_t cfg_s2_q;
  pmap_cfg_t cfg_l_q;
  pmap_cfg_t cfg_now;
  logic req_s1_q;
  logic req_s2_q;
  logic [WORD_BITS-1:0] hold_q;
  logic hold_full_q;
  logic din_s1_q;
  logic din_s2_q;
  logic [7:0] half_cnt_q;
  logic bclk_q;
  logic bit_rise;
  logic bit_fall;
  logic [7:0] bit_q;
  logic [7:0] nxt_bit;
  logic start_now;
  logic active_q;
  logic [3:0] tx_cnt_q;
  logic [WORD_BITS-1:0] tx_sh_q;
  logic [WORD_BITS-1:0] load_word;
  logic sync_q;
  logic dout_q;
  logic oe_q;
  logic [WORD_BITS-1:0] rx_sh_q;
  logic [WORD_BITS-1:0] rx_next;

  // Reset and inputs brought into the link domain, two flops each
  always_ff @(posedge link_clk_i) begin
    lrst_s1_q <= reset_i;
    link_rst <= lrst_s1_q;
    cfg_s1_q <= cfg_i;
    cfg_s2_q <= cfg_s1_q;
    req_s1_q <= req_q;
    req_s2_q <= req_s1_q;
    din_s1_q <= pcm_din_i;
    din_s2_q <= din_s1_q;
  end

  // Bit clock divider; the port always drives it, never follows one
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      half_cnt_q <= '0;
      bclk_q <= 1'b0;
    end else if (half_cnt_q == HALF_LAST) begin
      half_cnt_q <= '0;
      bclk_q <= ~bclk_q;
    end else begin
      half_cnt_q <= 8'(half_cnt_q + 1'b1);
    end
  end

  assign bit_rise = (half_cnt_q == HALF_LAST) && !bclk_q;
  assign bit_fall = (half_cnt_q == HALF_LAST) && bclk_q;
  assign nxt_bit = 8'(bit_q + 1'b1);
  // Mode changes take effect only at a frame boundary
  assign cfg_now = (nxt_bit == BIT_SYNC) ? cfg_s2_q : cfg_l_q;
  assign start_now = bit_rise && slot_start(cfg_now, nxt_bit);
  assign load_word = cfg_now.word16 ? hold_q : {hold_q[7:0], 8'h00};

  // Bit position within the 256-bit frame
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      bit_q <= BIT_RESET;
      cfg_l_q <= '0;
    end else if (bit_rise) begin
      bit_q <= nxt_bit;
      if (nxt_bit == BIT_SYNC) begin
        cfg_l_q <= cfg_s2_q;
      end
    end
  end

  // Frame sync: short pulse at bit 0, or word select in I2S
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      sync_q <= 1'b0;
    end else if (bit_rise) begin
      if (cfg_now.mode == PMAP_MODE_I2S) begin
        sync_q <= nxt_bit[7];
      end else begin
        sync_q <= (nxt_bit == BIT_SYNC);
      end
    end
  end

  // Holding word: captured from the mailbox, consumed at a slot start
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      hold_q <= '0;
      hold_full_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      if (start_now) begin
        hold_full_q <= 1'b0;
      end else if ((req_s2_q != ack_q) && !hold_full_q) begin
        hold_q <= mbox_q;
        hold_full_q <= 1'b1;
        ack_q <= req_s2_q;
      end
    end
  end

  // Transmit shifter, MSB first; an empty holding word sends silence
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      active_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_sh_q <= '0;
      dout_q <= 1'b0;
    end else if (bit_rise) begin
      if (slot_start(cfg_now, nxt_bit)) begin
        active_q <= 1'b1;
        tx_cnt_q <= word_last(cfg_now.word16);
        tx_sh_q <= hold_full_q ? load_word : '0;
        dout_q <= hold_full_q ? load_word[WORD_BITS-1] : 1'b0;
      end else if (active_q && (tx_cnt_q != 4'h0)) begin
        tx_cnt_q <= 4'(tx_cnt_q - 1'b1);
        tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
        dout_q <= tx_sh_q[WORD_BITS-2];
      end else if (active_q) begin
        active_q <= 1'b0;
        dout_q <= 1'b0;
      end
    end
  end

  // Output enable rises with the first bit and drops on the falling edge in the bit period after the last bit
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      oe_q <= 1'b0;
    end else if (start_now) begin
      oe_q <= 1'b1;
    end else if (bit_fall && !active_q) begin
      oe_q <= 1'b0;
    end
  end

  assign rx_next = {rx_sh_q[WORD_BITS-2:0], din_s2_q};

  // Receive shifter on falling edges, mid-bit of the codec's launch
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      rx_sh_q <= '0;
      rx_word_q <= '0;
      rx_tgl_q <= 1'b0;
    end else if (bit_fall && active_q) begin
      rx_sh_q <= rx_next;
      if (tx_cnt_q == 4'h0) begin
        rx_word_q <= cfg_l_q.word16 ? rx_next : {8'h00, rx_next[7:0]};
        rx_tgl_q <= ~rx_tgl_q;
      end
    end
  end

  // Pins straight from flops
  assign pcm_clk_o = bclk_q;
  assign pcm_sync_o = sync_q;
  assign pcm_dout_o = dout_q;
  assign pcm_dout_oe_o = oe_q;

  // Helper: link cycles since the last sync rise
  logic sync_d1_q;
  logic fr_seen_q;
  logic [15:0] fr_cnt_q;
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      sync_d1_q <= 1'b0;
      fr_seen_q <= 1'b0;
      fr_cnt_q <= '0;
    end else begin
      sync_d1_q <= sync_q;
      if (sync_q && !sync_d1_q) begin
        fr_cnt_q <= '0;
        fr_seen_q <= 1'b1;
      end else begin
        fr_cnt_q <= 16'(fr_cnt_q + 1'b1);
      end
    end
  end

  // Checks on the link side
  bclk_low_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $fell(bclk_q) |-> ##HALF_CYC $rose(bclk_q)) else $error("bit clock low time wrong");
  bclk_half_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $rose(bclk_q) |-> ##HALF_CYC $fell(bclk_q)) else $error("bit clock high time wrong");
  frame_period_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    (sync_q && !sync_d1_q && fr_seen_q) |-> (int'(fr_cnt_q) == FRAME_CYC - 1))
    else $error("frame period wrong");
  sync_width_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    ($rose(sync_q) && cfg_l_q.mode != PMAP_MODE_I2S) |-> ##BIT_CYC $fell(sync_q))
    else $error("short sync not one bit long");
  word_length_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $rose(active_q) |-> (tx_cnt_q == word_last(cfg_l_q.word16)))
    else $error("word length not as configured");
  launch_rise_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $changed(dout_q) |-> $rose(bclk_q)) else $error("data launched off a rising edge");
  release_fall_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $fell(oe_q) |-> ($fell(bclk_q) && !active_q)) else $error("release not on falling edge");
  i2s_select_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    (cfg_l_q.mode == PMAP_MODE_I2S && bit_q != BIT_SYNC) |-> (sync_q == bit_q[7]))
    else $error("word select out of step");
  sample_fall_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    $changed(rx_sh_q) |-> $fell(bclk_q)) else $error("receive sampled off a falling edge");

  // Main scenarios
  tdm_slot_c: cover property (@(posedge link_clk_i) disable iff (link_rst)
    start_now && cfg_now.mode == PMAP_MODE_TDM && nxt_bit != BIT_FIRST);
  i2s_right_c: cover property (@(posedge link_clk_i) disable iff (link_rst)
    start_now && nxt_bit == BIT_I2S_RIGHT);
  rx_word_c: cover property (@(posedge clock_i) disable iff (reset_i) rx_valid_o);
  fifo_full_c: cover property (@(posedge clock_i) disable iff (reset_i)
    tx_valid_i && !tx_ready_o);
endmodule

// ===== verif/pmap_codec_model.sv
// Behavioural codec model on the far side of the serial audio pins
`timescale 1ns/1ps

module pmap_codec_model import pmap_pkg::*; #(
  parameter real HALF_NS = 240.0
) (
  input wire logic reset_i,
  input wire pmap_cfg_t cfg_i,
  input wire logic bclk_i,
  input wire logic sync_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic din_o
);
  logic [15:0] got_q[$];
  logic [15:0] sent_q[$];
  int wire_bad = 0;
  int frames = 0;
  int bitn = -1;
  logic sync_prev = 1'b0;
  logic [15:0] tx_w = 16'h0000;
  logic [15:0] rx_w = 16'h0000;
  realtime t_rise = 0.0;
  realtime t_fall = 0.0;

  initial din_o = 1'b0;

  // Word length for the current setting
  function automatic int wbits();
    return cfg_i.word16 ? 16 : 8;
  endfunction

  // Offset of bit b in the active run, -1 when idle
  function automatic int offs(input int b);
    int w;
    w = wbits();
    if (cfg_i.mode == PMAP_MODE_I2S && b >= 129 && b <= 128 + w) return b - 129;
    if (cfg_i.mode == PMAP_MODE_TDM && b >= 1 && b <= TDM_SLOTS * w) return b - 1;
    if (b >= 1 && b <= w) return b - 1;
    return -1;
  endfunction

  function automatic bit off_half(input realtime d);
    return d > HALF_NS + 0.01 || d < HALF_NS - 0.01;
  endfunction

  // Widths and frame position start afresh after each reset
  always @(posedge reset_i) begin
    bitn = -1;
    t_rise = 0.0;
    t_fall = 0.0;
  end

  // Rising edge: frame tracking, sync shape, launch of our next bit
  always @(posedge bclk_i) begin
    realtime now;
    int o;
    bit i2s;
    now = $realtime;
    #1;
    i2s = cfg_i.mode == PMAP_MODE_I2S;
    if (t_fall > 0 && !reset_i && off_half(now - t_fall)) wire_bad++;
    t_rise = reset_i ? 0.0 : now;
    if (reset_i) bitn = -1;
    else if (bitn >= 0) begin
      bitn = (bitn + 1) % FRAME_BITS;
      if (sync_i !== (i2s ? bitn >= 128 : bitn == 0)) wire_bad++;
    end else if (i2s ? sync_i && !sync_prev : sync_i) begin
      bitn = i2s ? 128 : 0;
    end
    if (bitn == 0) frames++;
    sync_prev = sync_i;
    o = offs(bitn);
    if (o >= 0 && o % wbits() == 0) begin
      tx_w = cfg_i.word16 ? 16'($urandom) : {8'h00, 8'($urandom)};
      sent_q.push_back(tx_w);
    end
    // A released line keeps changing, so a stale bit cannot pass
    din_o = o >= 0 ? tx_w[wbits() - 1 - o % wbits()] : ~din_o;
  end

  // Falling edge: enable and idle level, capture of the device's bits
  always @(negedge bclk_i) begin
    realtime now;
    int o;
    now = $realtime;
    #1;
    if (t_rise > 0 && !reset_i && off_half(now - t_rise)) wire_bad++;
    t_fall = reset_i ? 0.0 : now;
    o = offs(bitn);
    if (bitn >= 0 && !reset_i) begin
      if (o >= 0 ? dout_oe_i !== 1'b1 : dout_i !== 1'b0) wire_bad++;
      if (o < 0 && offs(bitn - 1) < 0 && dout_oe_i !== 1'b0) wire_bad++;
      if (o >= 0) rx_w = {rx_w[14:0], dout_i};
      if (o >= 0 && o % wbits() == wbits() - 1) begin
        got_q.push_back(cfg_i.word16 ? rx_w : {8'h00, rx_w[7:0]});
      end
    end
  end
endmodule

// ===== verif/pmap_port_tb_top.sv
// Self-checking bench for the master audio port against a codec model
`timescale 1ns/1ps

module pmap_port_tb_top import pmap_pkg::*;;
  localparam int LINK_PS = 6000;
  localparam int HALF = 244000 / LINK_PS;
  localparam int FRAME_CYC = FRAME_BITS * 2 * HALF * LINK_PS / 1000 / 40;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  pmap_cfg_t cfg = '{mode: PMAP_MODE_PCM, word16: 1'b1};
  logic tx_valid = 1'b0;
  logic [WORD_BITS-1:0] tx_data = 16'h0000;
  logic tx_ready;
  logic rx_valid;
  logic [WORD_BITS-1:0] rx_data;
  logic pcm_clk;
  logic pcm_sync;
  logic pcm_dout;
  logic pcm_oe;
  logic pcm_din;
  int num_errors = 0;
  int n_tests = 0;
  int n_rx = 0;
  logic [15:0] exp_q[$];

  // System clock 40 ns; link clock 6 ns, no system clock edge on a link rising edge
  always #20 clk = ~clk;
  always #3 link_clk = ~link_clk;

  pmap_port #(.LINK_CLK_PS(LINK_PS)) dut (
    .clock_i(clk), .reset_i(rst), .link_clk_i(link_clk), .cfg_i(cfg),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .pcm_clk_o(pcm_clk),
    .pcm_sync_o(pcm_sync), .pcm_dout_o(pcm_dout), .pcm_dout_oe_o(pcm_oe),
    .pcm_din_i(pcm_din));

  pmap_codec_model #(.HALF_NS(HALF * LINK_PS / 1000.0)) codec (
    .reset_i(rst), .cfg_i(cfg), .bclk_i(pcm_clk), .sync_i(pcm_sync),
    .dout_i(pcm_dout), .dout_oe_i(pcm_oe), .din_o(pcm_din));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    #2;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #2;
    check("idle pins", 16'h0000, {13'h0000, pcm_clk, pcm_sync, pcm_oe});
    check("ready in reset", 16'h0000, {15'h0000, tx_ready});
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    check("ready after reset", 16'h0001, {15'h0000, tx_ready});
  endtask

  // Holds the word until an edge sees ready; the caller drops valid
  task automatic push(input logic [15:0] d, output int waits);
    waits = 0;
    tx_valid = 1'b1;
    tx_data = d;
    @(posedge clk);
    while (tx_ready !== 1'b1 && waits < 5000) begin
      waits++;
      @(posedge clk);
    end
    #2;
  endtask

  task automatic run_test(input pmap_mode_t m, input logic w16, input int n, input bit fill);
    int w;
    int k;
    int slots;
    logic [15:0] d;
    slots = m == PMAP_MODE_I2S ? 2 : (m == PMAP_MODE_TDM ? TDM_SLOTS : 1);
    cfg = '{mode: m, word16: w16};
    do_reset();
    exp_q.delete();
    codec.got_q.delete();
    codec.sent_q.delete();
    codec.wire_bad = 0;
    codec.frames = 0;
    n_rx = 0;
    for (k = 0; k < 2 * FRAME_CYC && codec.bitn < 0; k++) @(posedge clk);
    #2;
    for (k = 0; k < n; k++) begin
      d = 16'($urandom) | 16'h0001;
      push(d, w);
      check("push wait", 16'h0000, 16'(w >= 5000));
      exp_q.push_back(w16 ? d : {8'h00, d[7:0]});
      if (fill && w > 0) break;
    end
    tx_valid = 1'b0;
    if (fill) check("fill depth", 16'h0001, 16'(k >= 16 && k <= 19));
    repeat ((exp_q.size() / slots + 2) * FRAME_CYC) @(posedge clk);
    #2;
    // Slots before the first word arrives carry zeros
    while (codec.got_q.size() > 0 && codec.got_q[0] === 16'h0000) void'(codec.got_q.pop_front());
    foreach (exp_q[i]) begin
      d = codec.got_q.size() > 0 ? codec.got_q.pop_front() : 16'hxxxx;
      check("tx word", exp_q[i], d);
    end
    foreach (codec.got_q[i]) check("underrun slot", 16'h0000, codec.got_q[i]);
    check("wire shape", 16'h0000, 16'(codec.wire_bad));
    check("frames seen", 16'h0001, 16'(codec.frames >= 2));
    check("rx words seen", 16'h0001, 16'(n_rx > 0));
    $display("test mode %0d word16 %0d done", m, w16);
  endtask

  // Each received word against what the codec launched; mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (!rst && rx_valid === 1'b1 && codec.sent_q.size() > 0) begin
      n_rx++;
      check("rx word", codec.sent_q.pop_front(), rx_data);
    end
  end

  // Tests need about 24 frames; cut a hang well after that
  initial begin
    #(4_000_000);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(34));
    run_test(PMAP_MODE_PCM, 1'b1, 2, 1'b0);
    run_test(PMAP_MODE_PCM, 1'b0, 2, 1'b0);
    run_test(PMAP_MODE_I2S, 1'b1, 2, 1'b0);
    run_test(PMAP_MODE_TDM, 1'b1, 4, 1'b0);
    run_test(PMAP_MODE_TDM, 1'b0, 20, 1'b1);
    run_test(pmap_mode_t'(2'b11), 1'b1, 1, 1'b0);
    summarize();
  end
endmodule
